// File: design/ccm_cfg.svh
// Constants of the chip configuration register bank: offsets, fields,
// reset values and bus watch timings.
// Assumes byte addresses relative to the peripheral base.
`ifndef CCM_CFG_SVH
`define CCM_CFG_SVH

`define CCM_OFS_CTRL        24'h110004
`define CCM_OFS_DEFAULTS    24'h110008
`define CCM_OFS_TESTLOCK    24'h11000c
`define CCM_OFS_UNIMPL      24'h110010

`define CCM_BIT_LOAD        15
`define CCM_BIT_SIZE_EN     6
`define CCM_BIT_TRACE_EN    5
`define CCM_BIT_WATCH_EN    3
`define CCM_MODE_SINGLE     3'h6
`define CCM_MODE_MASTER     3'h7

`define CCM_RST_WATCH_EN    1'h1
`define CCM_RST_TIMEOUT     3'h0
`define CCM_RST_TRACE_EN    1'h0

`define CCM_WATCH_MAX_CLKS  32'h00010000
`define CCM_WATCH_MIN_CLKS  32'h00000200

`endif

// File: design/ccm_pkg.sv
// Types shared by the chip configuration register bank.
// Assumes the constants header is included before use of offsets.
package ccm_pkg;

    typedef struct packed {
        logic        sel;
        logic        wr;
        logic        supervisor;
        logic [23:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } ccm_req_t;

    typedef struct packed {
        logic        ack;
        logic        terr;
        logic [31:0] rdata;
    } ccm_rsp_t;

    typedef struct packed {
        logic       master_mode;
        logic       full_drive;
        logic [1:0] cs_cfg;
        logic [1:0] boot_size;
        logic       boot_ext;
    } ccm_strap_t;

    typedef struct packed {
        logic       full_drive;
        logic       size_pin_enable;
        logic       trace_pin_enable;
        logic       bus_watch_enable;
        logic [2:0] bus_watch_timeout;
    } ccm_ctrl_t;

    typedef enum logic [2:0] {
        CCM_ST_RESET = 3'b001,
        CCM_ST_LOAD  = 3'b010,
        CCM_ST_RUN   = 3'b100
    } ccm_state_t;

endpackage : ccm_pkg

// File: design/ccm_write_once.sv
// One write-once register field.
// Assumes load and we are same-clock pulses from the register bank.
`timescale 1ns/1ps

module ccm_write_once #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         we,
    input  wire logic         debug,
    input  wire logic [W-1:0] wval,
    output logic      [W-1:0] q
);

    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;
    logic         done_r;
    logic         done_nxt;
    logic         sticky_r;
    logic         sticky_nxt;

    always_comb begin
        q_nxt      = q_r;
        done_nxt   = done_r;
        sticky_nxt = sticky_r;
        if (load) begin
            q_nxt      = load_val;
            done_nxt   = 1'b0;
            sticky_nxt = 1'b0;
        end else if (we && (!done_r || debug || sticky_r)) begin
            q_nxt    = wval;
            done_nxt = 1'b1;
            // A debug write keeps the field open after debug ends.
            if (debug) begin
                sticky_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q_r      <= '0;
            done_r   <= 1'b0;
            sticky_r <= 1'b0;
        end else begin
            q_r      <= q_nxt;
            done_r   <= done_nxt;
            sticky_r <= sticky_nxt;
        end
    end

    assign q = q_r;

endmodule : ccm_write_once

// File: design/ccm_regs.sv
// Chip configuration register bank on the internal peripheral bus.
// Assumes straps are stable pins sampled at reset release; debug from logic.
`timescale 1ns/1ps
`include "ccm_cfg.svh"

// Summary of operation
// - Only supervisor accesses; user gets transfer error
// - Unimplemented location errors, no effect
// - Reserved word reads zero; test risk
// - Control/low-power share word; defaults/id next
// - Drive and mode from straps if cfg_override_n low; watch set
// - Size pin enable resets to master mode
// - Bit 15 write-once full drive select
// - Bits 10:8 read-only mode, 110/111
// - Bit 6 size pin function enable
// - Bit 5 trace pin functions enable
// - Bit 3 write-once bus watch enable
// - Bits 2:0 write-once watch timeout select
// - Defaults read-only, override only via strap pin
// - Write-once readable, debug keeps writable
// - Identification: part 15:8, revision 7:0
module ccm_regs #(
    parameter logic [7:0] PART_NUM = 8'h5a,  // Arbitrary value.
    parameter logic [7:0] REV_NUM  = 8'h01   // Arbitrary value.
) (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire ccm_pkg::ccm_req_t   req,
    output ccm_pkg::ccm_rsp_t        rsp,
    input  wire logic                cfg_override_n,
    input  wire ccm_pkg::ccm_strap_t strap_pins,
    input  wire logic                debug_mode,
    output ccm_pkg::ccm_ctrl_t       ctrl,
    output logic [15:0]              low_power_control,
    output logic [31:0]              bus_watch_clocks,
    output logic                     test_mode
);
    import ccm_pkg::*;

    // ********************************************************
    // Pin synchronisers and reset configuration capture
    // ********************************************************
    logic       ovr_s1_r;
    logic       ovr_s2_r;
    ccm_strap_t strap_s1_r;
    ccm_strap_t strap_s2_r;
    ccm_strap_t dflt_r;
    ccm_strap_t dflt_nxt;
    ccm_state_t state_r;
    ccm_state_t state_nxt;
    logic       load;

    // Straps are caught on the second clock after release, from settled synchronisers.
    always_comb begin
        state_nxt = state_r;
        dflt_nxt  = dflt_r;
        load      = 1'b0;
        case (state_r)
            CCM_ST_RESET: state_nxt = CCM_ST_LOAD;
            CCM_ST_LOAD: begin
                load      = 1'b1;
                state_nxt = CCM_ST_RUN;
                if (!ovr_s2_r) begin
                    dflt_nxt = strap_s2_r;
                end else begin
                    dflt_nxt = '0;
                    dflt_nxt.full_drive = 1'b1;
                end
            end
            CCM_ST_RUN: state_nxt = CCM_ST_RUN;
            default:    state_nxt = CCM_ST_RESET;
        endcase
    end

    // The pins are sampled under reset as well, so the load state reads
    // the levels held during reset rather than a cleared synchroniser.
    always_ff @(posedge mclk) begin
        ovr_s1_r   <= cfg_override_n;
        ovr_s2_r   <= ovr_s1_r;
        strap_s1_r <= strap_pins;
        strap_s2_r <= strap_s1_r;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            dflt_r  <= '0;
            state_r <= CCM_ST_RESET;
        end else begin
            dflt_r  <= dflt_nxt;
            state_r <= state_nxt;
        end
    end

    // ********************************************************
    // Access decode
    // ********************************************************
    function automatic logic hit(input logic [23:0] a, input logic [23:0] o);
        hit = (a[23:2] == o[23:2]);
    endfunction : hit

    logic acc;
    logic ok;
    logic wr_ok;
    logic hit_ctrl;
    logic hit_dflt;
    logic hit_test;

    assign acc      = req.sel && (state_r == CCM_ST_RUN);
    assign hit_ctrl = hit(req.addr, `CCM_OFS_CTRL);
    assign hit_dflt = hit(req.addr, `CCM_OFS_DEFAULTS);
    assign hit_test = hit(req.addr, `CCM_OFS_TESTLOCK);
    assign ok       = req.supervisor
                      && (hit_ctrl || hit_dflt || hit_test);
    assign wr_ok    = acc && ok && req.wr;

    logic we_hi;
    logic we_lo;
    assign we_hi = wr_ok && hit_ctrl && (req.be[3:2] != 2'h0);
    assign we_lo = wr_ok && hit_ctrl && (req.be[1:0] != 2'h0);

    // ********************************************************
    // Control fields
    // ********************************************************
    logic [2:0]  mode;
    logic [15:0] w_hi;
    logic        load_drive;
    logic [0:0]  q_drive;
    logic [0:0]  q_wen;
    logic [2:0]  q_tmo;

    assign w_hi       = req.wdata[31:16];
    assign mode       = dflt_r.master_mode ? `CCM_MODE_MASTER
                                           : `CCM_MODE_SINGLE;
    assign load_drive = dflt_r.full_drive;

    ccm_write_once #(.W(1)) u_drive (
        .mclk(mclk), .rst(rst), .load(load), .load_val(dflt_nxt.full_drive),
        .we(we_hi), .debug(debug_mode), .wval(w_hi[`CCM_BIT_LOAD]),
        .q(q_drive));
    ccm_write_once #(.W(1)) u_wen (
        .mclk(mclk), .rst(rst), .load(load), .load_val(`CCM_RST_WATCH_EN),
        .we(we_hi), .debug(debug_mode), .wval(w_hi[`CCM_BIT_WATCH_EN]),
        .q(q_wen));
    ccm_write_once #(.W(3)) u_tmo (
        .mclk(mclk), .rst(rst), .load(load), .load_val(`CCM_RST_TIMEOUT),
        .we(we_hi), .debug(debug_mode), .wval(w_hi[2:0]),
        .q(q_tmo));

    logic        size_en_r;
    logic        size_en_nxt;
    logic        trace_en_r;
    logic        trace_en_nxt;
    logic [15:0] lpc_r;
    logic [15:0] lpc_nxt;
    logic        test_r;
    logic        test_nxt;

    always_comb begin
        size_en_nxt  = size_en_r;
        trace_en_nxt = trace_en_r;
        lpc_nxt      = lpc_r;
        test_nxt     = test_r;
        if (load) begin
            size_en_nxt  = dflt_nxt.master_mode;
            trace_en_nxt = `CCM_RST_TRACE_EN;
        end else begin
            if (we_hi) begin
                size_en_nxt  = w_hi[`CCM_BIT_SIZE_EN];
                trace_en_nxt = w_hi[`CCM_BIT_TRACE_EN];
            end
            if (we_lo) begin
                lpc_nxt = req.wdata[15:0];
            end
            // Any nonzero reserved write arms test mode; a zero write clears it.
            if (wr_ok && hit_test) begin
                test_nxt = (req.wdata != 32'h0);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            size_en_r  <= 1'b0;
            trace_en_r <= 1'b0;
            lpc_r      <= 16'h0;
            test_r     <= 1'b0;
        end else begin
            size_en_r  <= size_en_nxt;
            trace_en_r <= trace_en_nxt;
            lpc_r      <= lpc_nxt;
            test_r     <= test_nxt;
        end
    end

    // ********************************************************
    // Read data and termination
    // ********************************************************
    logic [15:0] ctrl_word;
    logic [15:0] dflt_word;
    ccm_rsp_t    rsp_r;
    ccm_rsp_t    rsp_nxt;

    assign ctrl_word = {q_drive, 4'h0, mode, 1'h0, size_en_r, trace_en_r,
                        1'h0, q_wen, q_tmo};
    assign dflt_word = {6'h0, dflt_r.cs_cfg, 2'h0, load_drive,
                        dflt_r.boot_size, dflt_r.boot_ext, 1'h0,
                        dflt_r.master_mode};

    always_comb begin
        rsp_nxt = '0;
        if (acc) begin
            rsp_nxt.ack  = ok;
            rsp_nxt.terr = !ok;
            if (ok && !req.wr) begin
                if (hit_ctrl) begin
                    rsp_nxt.rdata = {ctrl_word, lpc_r};
                end else if (hit_dflt) begin
                    rsp_nxt.rdata = {dflt_word, PART_NUM, REV_NUM};
                end else begin
                    rsp_nxt.rdata = 32'h0;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    // Timeout code n selects the longest period shifted right n times.
    assign bus_watch_clocks = `CCM_WATCH_MAX_CLKS >> q_tmo;
    assign rsp               = rsp_r;
    assign low_power_control = lpc_r;
    assign test_mode         = test_r;
    assign ctrl = '{full_drive:        q_drive[0],
                    size_pin_enable:   size_en_r,
                    trace_pin_enable:  trace_en_r,
                    bus_watch_enable:  q_wen[0],
                    bus_watch_timeout: q_tmo};

endmodule : ccm_regs

// File: sim/ccm_regs_chk.sv
// Port checker for the configuration register bank.
// Assumes it is bound to ccm_regs and shares its single clock.
`timescale 1ns/1ps
module ccm_regs_chk #(
    parameter logic [7:0] PART_NUM = 8'h5a,
    parameter logic [7:0] REV_NUM  = 8'h01
) (
    input wire logic               mclk,
    input wire logic               rst,
    input wire ccm_pkg::ccm_req_t  req,
    input wire ccm_pkg::ccm_rsp_t  rsp,
    input wire logic               debug_mode,
    input wire ccm_pkg::ccm_ctrl_t ctrl,
    input wire logic [31:0]        bus_watch_clocks,
    input wire logic               test_mode
);
    import ccm_pkg::*;
    // ****
    // Helpers
    // ****
    logic [1:0] age_r;
    logic       lock_r;
    logic       dbg_r;
    logic       up;
    logic       rd_op;
    logic       wr_op;
    // Requests before the third edge after reset are ignored.
    assign up    = age_r[1] && req.sel;
    assign rd_op = up && req.supervisor && !req.wr;
    assign wr_op = up && req.supervisor && req.wr;
    always_ff @(posedge mclk) begin
        if (rst) begin
            age_r  <= 2'h0;
            lock_r <= 1'h0;
            dbg_r  <= 1'h0;
        end else begin
            age_r <= age_r | {age_r[0], 1'h1};
            if (wr_op && req.addr == 24'h110004 && |req.be[3:2]) begin
                lock_r <= lock_r | !debug_mode;
                dbg_r  <= dbg_r | debug_mode;
            end
        end
    end
    sequence s_ok;
        rsp.ack && !rsp.terr;
    endsequence
    sequence s_err;
        rsp.terr && !rsp.ack && rsp.rdata == 32'h0;
    endsequence
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ****
    // Assertions
    // ****
    a_resp_cause: assert property (
        (rsp.ack || rsp.terr) |-> $past(req.sel))
        else $error("response without request");
    a_user_error: assert property (
        up && !req.supervisor |=> s_err and $stable(ctrl))
        else $error("user access not refused");
    a_unimpl_error: assert property (
        up && req.supervisor && req.addr == 24'h110010 |=> s_err)
        else $error("unimplemented word not refused");
    a_reserved_zero: assert property (
        rd_op && req.addr == 24'h11000c |=> s_ok ##0 rsp.rdata == 32'h0)
        else $error("reserved word not zero");
    a_test_lock: assert property (
        wr_op && req.addr == 24'h11000c
        |=> s_ok ##0 test_mode == ($past(req.wdata) != 32'h0))
        else $error("test mode wrong");
    a_defaults_ro: assert property (
        wr_op && req.addr == 24'h110008 |=> s_ok ##0 $stable(ctrl))
        else $error("defaults write changed control");
    a_id_fields: assert property (
        rd_op && req.addr == 24'h110008
        |=> s_ok ##0 rsp.rdata[15:0] == {PART_NUM, REV_NUM})
        else $error("identification wrong");
    a_ctrl_readback: assert property (
        rd_op && req.addr == 24'h110004 |=> s_ok ##0
        rsp.rdata[31:16] == {ctrl.full_drive, 6'h3, rsp.rdata[24], 1'h0,
        ctrl.size_pin_enable, ctrl.trace_pin_enable, 1'h0,
        ctrl.bus_watch_enable, ctrl.bus_watch_timeout})
        else $error("control readback wrong");
    a_once_locked: assert property (
        wr_op && lock_r && !dbg_r && !debug_mode && req.addr == 24'h110004
        |=> $stable({ctrl.full_drive, ctrl.bus_watch_enable,
        ctrl.bus_watch_timeout}))
        else $error("write-once field rewritten");
    a_timeout_map: assert property (
        age_r[1] |-> bus_watch_clocks == 32'h10000 >> ctrl.bus_watch_timeout)
        else $error("timeout clocks wrong");
endmodule : ccm_regs_chk

bind ccm_regs ccm_regs_chk #(.PART_NUM(PART_NUM), .REV_NUM(REV_NUM)) i_chk (
    .mclk(mclk), .rst(rst), .req(req), .rsp(rsp), .debug_mode(debug_mode),
    .ctrl(ctrl), .bus_watch_clocks(bus_watch_clocks), .test_mode(test_mode));

// File: sim/ccm_regs_bench.sv
// Self-checking bench of the configuration register bank.
// Assumes default identification parameters of the design.
`timescale 1ns/1ps
module ccm_regs_bench;
    import ccm_pkg::*;
    // ****
    // Stimulus
    // ****
    typedef struct packed {
        logic [1:0]  op;
        logic [23:0] a;
        logic [31:0] d;
        logic [3:0]  be;
        logic [1:0]  fl;
        logic [31:0] rd;
    } ccm_row_t;
    localparam logic [23:0] A4 = 24'h110004;
    localparam logic [23:0] A8 = 24'h110008;
    localparam logic [23:0] AC = 24'h11000c;
    // Op is {write, supervisor}; fl is {transfer error, test mode}.
    ccm_row_t rows [18] = '{
        '{2'h3, AC, 32'h0, 4'hf, 2'h0, 32'h0},
        '{2'h1, A4, 32'h0, 4'hf, 2'h0, 32'h86080000},
        '{2'h1, A8, 32'h0, 4'hf, 2'h0, 32'h00205a01},
        '{2'h1, AC, 32'h0, 4'hf, 2'h0, 32'h0},
        '{2'h1, 24'h110010, 32'h0, 4'hf, 2'h2, 32'h0},
        '{2'h3, 24'h110010, 32'hffffffff, 4'hf, 2'h2, 32'h0},
        '{2'h0, A4, 32'h0, 4'hf, 2'h2, 32'h0},
        '{2'h2, A4, 32'h00001234, 4'hf, 2'h2, 32'h0},
        '{2'h1, A4, 32'h0, 4'hf, 2'h0, 32'h86080000},
        '{2'h3, A8, 32'hffffffff, 4'hf, 2'h0, 32'h0},
        '{2'h3, A4, 32'h0067abcd, 4'hf, 2'h0, 32'h0},
        '{2'h1, A4, 32'h0, 4'hf, 2'h0, 32'h0667abcd},
        '{2'h3, A4, 32'h80080000, 4'hc, 2'h0, 32'h0},
        '{2'h1, A4, 32'h0, 4'hf, 2'h0, 32'h0607abcd},
        '{2'h1, A8, 32'h0, 4'hf, 2'h0, 32'h00205a01},
        '{2'h3, AC, 32'h1, 4'hf, 2'h1, 32'h0},
        '{2'h1, AC, 32'h0, 4'hf, 2'h1, 32'h0},
        '{2'h3, AC, 32'h0, 4'hf, 2'h0, 32'h0}};
    logic        mclk;
    logic        rst;
    logic        cfg_override_n;
    logic        debug_mode;
    ccm_req_t    req;
    ccm_rsp_t    rsp;
    ccm_strap_t  strap_pins;
    ccm_ctrl_t   ctrl;
    logic [15:0] low_power_control;
    logic [31:0] bus_watch_clocks;
    logic        test_mode;
    int          errors = 0;
    int          checks = 0;
    int          cycles = 0;
    ccm_regs i_dut (.mclk(mclk), .rst(rst), .req(req), .rsp(rsp),
        .cfg_override_n(cfg_override_n), .strap_pins(strap_pins),
        .debug_mode(debug_mode), .ctrl(ctrl),
        .low_power_control(low_power_control),
        .bus_watch_clocks(bus_watch_clocks), .test_mode(test_mode));
    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic acc(logic [1:0] op, logic [23:0] a, logic [31:0] d,
                       logic [3:0] be);
        @(posedge mclk);
        req <= '{1'h1, op[1], op[0], a, d, be};
        @(posedge mclk);
        req.sel <= 1'h0;
        #1;
    endtask : acc
    task automatic do_reset();
        rst <= 1'h1;
        repeat (5) @(posedge mclk);
        rst <= 1'h0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : do_reset
    task automatic summarize();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // A hang counts against the run rather than stalling it.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 1000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        rst = 1'h1;
        req = '0;
        cfg_override_n = 1'h1;
        strap_pins = '0;
        debug_mode = 1'h0;
        do_reset();
        foreach (rows[i]) begin
            acc(rows[i].op, rows[i].a, rows[i].d, rows[i].be);
            chk("terr", 32'(rsp.terr), 32'(rows[i].fl[1]));
            chk("ack", 32'(rsp.ack), 32'(!rows[i].fl[1]));
            chk("rdata", rsp.rdata, rows[i].rd);
            chk("test_mode", 32'(test_mode), 32'(rows[i].fl[0]));
        end
        chk("clocks", bus_watch_clocks, 32'h200);
        chk("ctrl", 32'(ctrl), 32'h07);
        chk("low_power", 32'(low_power_control), 32'h0000abcd);
        $display("test table done");
        @(posedge mclk) debug_mode <= 1'h1;
        acc(2'h3, A4, 32'h800a0000, 4'hc);
        @(posedge mclk) debug_mode <= 1'h0;
        acc(2'h3, A4, 32'h00050000, 4'hc);
        chk("clocks", bus_watch_clocks, 32'h800);
        chk("ctrl", 32'(ctrl), 32'h05);
        $display("test debug done");
        @(posedge mclk);
        cfg_override_n <= 1'h0;
        strap_pins <= '{1'h1, 1'h0, 2'h1, 2'h2, 1'h1};
        do_reset();
        chk("ctrl", 32'(ctrl), 32'h28);
        acc(2'h1, A4, 32'h0, 4'hf);
        chk("rdata", rsp.rdata, 32'h07480000);
        acc(2'h1, A8, 32'h0, 4'hf);
        chk("rdata", rsp.rdata, 32'h01155a01);
        $display("test override done");
        summarize();
    end
endmodule : ccm_regs_bench
